// ==== hdl/rms_sequencer.sv ====
// Reset stretching, cause capture, boot mode select and debug link pin
`timescale 1ns/1ns
module rms_sequencer (
  input wire logic clk,
  input wire logic rst,
  input wire logic internal_reset_req,
  input wire logic debug_force_reset_bit,
  input wire logic fast_clock_select,
  input wire logic fast_debug_clock_tick,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic debug_and_mode_pin_in,
  output logic debug_and_mode_pin_out,
  output logic debug_and_mode_pin_oe,
  input wire logic link_start,
  input wire logic link_tx_bit,
  input wire logic link_drive,
  output logic link_busy,
  output logic link_rx_bit,
  output logic link_done,
  output logic [3:0] reset_cause_register,
  output logic system_reset,
  output logic background_debug_state,
  output logic system_bus_clock,
  output logic external_clock_selected
);
  rms_pkg::rms_state_t state;
  logic [7:0] stretch;
  logic mode_window;
  logic prev_pin;
  logic pin_fall;
  logic tick;
  logic bus_phase;
  rms_bit_if bi ();

  // Pin level as the device sees it, own drive included
  function automatic logic pin_is_low(input logic drv, input logic level);
    return drv || !level;
  endfunction

  // ==========================================================
  // Reset stretch sequence
  // Edge on the reset pin so our own stretch cannot retrigger itself
  assign pin_fall = prev_pin && !reset_pin_in;

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      prev_pin <= 1'b1;
    else
      prev_pin <= reset_pin_in || reset_pin_oe;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= rms_pkg::RMS_POWER;
      stretch <= 8'h0000;
    end else begin
      case (state)
        rms_pkg::RMS_POWER: begin
          state <= rms_pkg::RMS_STRETCH;
          stretch <= 8'h0000;
        end
        rms_pkg::RMS_STRETCH: begin
          if (stretch == 8'(rms_pkg::RESET_STRETCH_CLKS - 1))
            state <= rms_pkg::RMS_RUN;
          else
            stretch <= stretch + 8'h0001;
        end
        rms_pkg::RMS_RUN: begin
          if (internal_reset_req || debug_force_reset_bit || pin_fall) begin
            state <= rms_pkg::RMS_STRETCH;
            stretch <= 8'h0000;
          end
        end
        default: state <= rms_pkg::RMS_POWER;
      endcase
    end
  end

  // Pin is driven low by the open-drain buffer while stretching
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_pin_oe <= 1'b1;
      reset_pin_out <= 1'b0;
      system_reset <= 1'b1;
    end else begin
      reset_pin_out <= 1'b0;
      reset_pin_oe <= state != rms_pkg::RMS_RUN &&
        !(state == rms_pkg::RMS_STRETCH &&
          stretch == 8'(rms_pkg::RESET_STRETCH_CLKS - 1));
      system_reset <= state != rms_pkg::RMS_RUN ||
        internal_reset_req || debug_force_reset_bit || pin_fall;
    end
  end

  // ==========================================================
  // Reset cause and mode window
  // One cause bit per reset
  // Mode window only for power-on and forced resets
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_cause_register <= rms_pkg::CAUSE_RESET;
      mode_window <= 1'b1;
    end else if (state == rms_pkg::RMS_RUN) begin
      if (debug_force_reset_bit) begin
        reset_cause_register <= 4'h0001 << rms_pkg::CAUSE_DBG;
        mode_window <= 1'b1;
      end else if (internal_reset_req) begin
        reset_cause_register <= 4'h0001 << rms_pkg::CAUSE_INT;
        mode_window <= 1'b0;
      end else if (pin_fall) begin
        // Pin reset never opens the mode window
        reset_cause_register <= 4'h0001 << rms_pkg::CAUSE_PIN;
        mode_window <= 1'b0;
      end
    end
  end

  // Pin reset returns to user mode even after a background start
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      background_debug_state <= 1'b0;
    else if (state == rms_pkg::RMS_STRETCH &&
             stretch == 8'(rms_pkg::RESET_STRETCH_CLKS - 1)) begin
      if (mode_window)
        background_debug_state <= pin_is_low(1'b0, debug_and_mode_pin_in);
      else if (reset_cause_register[rms_pkg::CAUSE_PIN])
        background_debug_state <= 1'b0;
    end
  end

  // ==========================================================
  // Clocks
  // Bus clock toggles every generator cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      bus_phase <= 1'b0;
    else
      bus_phase <= !bus_phase;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      system_bus_clock <= 1'b0;
    else
      system_bus_clock <= !bus_phase;
  end

  // Internal generator selected after every reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      external_clock_selected <= 1'b0;
    else if (system_reset)
      external_clock_selected <= 1'b0;
  end

  // Fast clock or bus rate as debug clock
  assign tick = fast_clock_select ? fast_debug_clock_tick : bus_phase;

  // ==========================================================
  // Debug link
  // No link bit starts and the pin is not driven while reset holds the pin as a mode input; a bit already running keeps counting
  assign bi.start = link_start && !system_reset;
  assign bi.tx_bit = link_tx_bit;
  assign bi.drive_tx = link_drive;

  rms_bit_timer i_rms_bit_timer (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .pin_in(debug_and_mode_pin_in),
    .bi(bi)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      debug_and_mode_pin_out <= 1'b1;
      debug_and_mode_pin_oe <= 1'b0;
      link_busy <= 1'b0;
      link_rx_bit <= 1'b1;
      link_done <= 1'b0;
    end else begin
      debug_and_mode_pin_out <= !bi.pin_low;
      debug_and_mode_pin_oe <= !system_reset && (bi.pin_low || bi.pin_high);
      link_busy <= bi.busy;
      link_rx_bit <= bi.rx_bit;
      link_done <= bi.done;
    end
  end
endmodule // rms_sequencer

// ==== hdl/rms_pkg.sv ====
// Constants and types for the reset and boot-mode sequencer
package rms_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned RESET_STRETCH_BUS_CYCLES = 66;
  // Bus clock is half the generator output, which runs at clk
  localparam int unsigned RESET_STRETCH_CLKS = RESET_STRETCH_BUS_CYCLES * 2;
  localparam int unsigned STRETCH_W = 8;
  localparam int unsigned BIT_CLKS = 16;
  localparam int unsigned BIT_W = 4;
  localparam logic [3:0] BIT_LAST = 4'h000F;
  localparam logic [3:0] SPEEDUP_LAST = 4'h0001;
  localparam logic [3:0] SAMPLE_AT = 4'h000A;
  localparam logic [3:0] LOW1_LAST = 4'h0003;
  localparam logic [3:0] LOW0_LAST = 4'h000C;

  // ==========================================================
  // Reset cause bit positions
  localparam int unsigned CAUSE_W = 4;
  localparam int unsigned CAUSE_POR = 0;
  localparam int unsigned CAUSE_PIN = 1;
  localparam int unsigned CAUSE_INT = 2;
  localparam int unsigned CAUSE_DBG = 3;
  localparam logic [3:0] CAUSE_RESET = 4'h0001;

  typedef enum logic [1:0] {
    RMS_POWER = 2'b00,
    RMS_STRETCH = 2'b01,
    RMS_RUN = 2'b11
  } rms_state_t;
endpackage

// ==== hdl/rms_bit_if.sv ====
// Bit-time link between the sequencer and its bit timer
`timescale 1ns/1ns
interface rms_bit_if;
  logic start;
  logic tx_bit;
  logic drive_tx;
  logic busy;
  logic rx_bit;
  logic done;
  logic pin_low;
  logic pin_high;
  modport ctrl (output start, output tx_bit, output drive_tx, input busy, input rx_bit,
    input done, input pin_low, input pin_high);
  modport timer (input start, input tx_bit, input drive_tx, output busy, output rx_bit,
    output done, output pin_low, output pin_high);
endinterface

// ==== hdl/rms_bit_timer.sv ====
// Sixteen-tick bit timer of the single-wire debug link
`timescale 1ns/1ns
module rms_bit_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic pin_in,
  rms_bit_if.timer bi
);
  logic [3:0] count;
  logic sent;
  logic drive;

  // ==========================================================
  // Bit counter
  // Sixteen-tick bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 4'h0000;
      bi.busy <= 1'b0;
      sent <= 1'b0;
      drive <= 1'b0;
    end else if (!bi.busy) begin
      if (bi.start) begin
        bi.busy <= 1'b1;
        count <= 4'h0000;
        sent <= bi.tx_bit;
        drive <= bi.drive_tx;
      end
    end else if (tick) begin
      count <= count + 4'h0001;
      if (count == rms_pkg::BIT_LAST)
        bi.busy <= 1'b0;
    end
  end

  // ==========================================================
  // Sampling and pin drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bi.rx_bit <= 1'b1;
      bi.done <= 1'b0;
    end else begin
      bi.done <= bi.busy && tick && count == rms_pkg::BIT_LAST;
      if (bi.busy && tick && count == rms_pkg::SAMPLE_AT)
        bi.rx_bit <= pin_in;
    end
  end

  // Low phase then short speed-up drive high
  always_comb begin
    bi.pin_low = bi.busy && drive &&
      (count <= (sent ? rms_pkg::LOW1_LAST : rms_pkg::LOW0_LAST));
    bi.pin_high = bi.busy && drive && !bi.pin_low &&
      (count <= (sent ? rms_pkg::LOW1_LAST : rms_pkg::LOW0_LAST) + rms_pkg::SPEEDUP_LAST);
  end
endmodule // rms_bit_timer

// ==== test/rms_sequencer_assertions.sv ====
// Checker for the reset and boot-mode sequencer
`timescale 1ns/1ns
module rms_sequencer_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic internal_reset_req,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic debug_and_mode_pin_oe,
  input wire logic debug_and_mode_pin_out,
  input wire logic link_busy,
  input wire logic link_done,
  input wire logic [3:0] reset_cause_register,
  input wire logic system_reset,
  input wire logic background_debug_state,
  input wire logic system_bus_clock,
  input wire logic external_clock_selected
);
  logic [7:0] low_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Stretch counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= reset_pin_oe ? low_cnt + 8'h01 : 8'h00;
    end
  end
  // ==========================================================
  // Properties
  a_pin_never_high: assert property (reset_pin_out == 1'b0)
    else $error("reset pin driven high");
  // Slack of a few clocks for the power-up cycle and bus phase
  a_stretch_length: assert property ($fell(reset_pin_oe) |-> low_cnt >= 8'h82 && low_cnt <= 8'h87)
    else $error("reset stretch length wrong");
  a_request_answer: assert property (internal_reset_req && !system_reset && !reset_pin_oe |-> ##2 reset_pin_oe)
    else $error("internal request not answered");
  a_cause_onehot: assert property ($onehot(reset_cause_register))
    else $error("reset cause not one-hot");
  a_pin_user_mode: assert property ($fell(system_reset) && reset_cause_register[1] |-> !background_debug_state)
    else $error("pin reset entered background");
  a_mode_latched: assert property (!system_reset && !$past(system_reset) |-> $stable(background_debug_state))
    else $error("mode changed outside reset");
  a_pin_as_mode: assert property (system_reset |-> !debug_and_mode_pin_oe)
    else $error("debug pin driven during reset");
  a_bus_half_rate: assert property ($changed(system_bus_clock) |=> $changed(system_bus_clock))
    else $error("bus clock not half rate");
  a_internal_clock: assert property (!external_clock_selected)
    else $error("external clock selected");
  a_pin_reset: assert property ($fell(reset_pin_in) && !reset_pin_oe && !system_reset |-> ##2 reset_pin_oe)
    else $error("external reset pin low not answered");
  a_done_at_end: assert property ($fell(link_busy) |-> link_done)
    else $error("bit end without done pulse");
  a_speedup_brief: assert property (debug_and_mode_pin_oe && debug_and_mode_pin_out |-> ##2 !(debug_and_mode_pin_oe && debug_and_mode_pin_out))
    else $error("speed-up drive too long");
  c_link_bit: cover property ($fell(link_busy));
  c_background: cover property ($fell(system_reset) && background_debug_state);
  c_pin_reset: cover property ($rose(reset_cause_register[1]));
  c_force_reset: cover property ($rose(reset_cause_register[3]));
endmodule // rms_sequencer_checker
bind rms_sequencer rms_sequencer_checker i_rms_sequencer_checker (.*);

// ==== test/rms_board_model.sv ====
// Board reset wiring and debug pod model
`timescale 1ns/1ns
module rms_board_model (
  input wire logic press_reset,
  input wire logic hold_mode_low,
  input wire logic reset_pin_oe,
  input wire logic debug_and_mode_pin_out,
  input wire logic debug_and_mode_pin_oe,
  output logic reset_pin_in,
  output logic debug_and_mode_pin_in
);
  assign reset_pin_in = !(reset_pin_oe || press_reset);
  assign debug_and_mode_pin_in = debug_and_mode_pin_oe ? debug_and_mode_pin_out : !hold_mode_low;
endmodule // rms_board_model

// ==== test/tb_rms_sequencer.sv ====
// Self-checking bench for the reset and boot-mode sequencer
`timescale 1ns/1ns
module tb_rms_sequencer;
  logic clk = 0, rst = 1, internal_reset_req = 0, debug_force_reset_bit = 0;
  logic fast_clock_select = 0, fast_debug_clock_tick = 1, link_start = 0, link_tx_bit = 0;
  logic link_drive = 1, press_reset = 0, hold_mode_low = 0;
  logic reset_pin_in, reset_pin_out, reset_pin_oe, debug_and_mode_pin_in;
  logic debug_and_mode_pin_out, debug_and_mode_pin_oe, link_busy, link_rx_bit, link_done;
  logic system_reset, background_debug_state, system_bus_clock, external_clock_selected;
  logic [3:0] reset_cause_register;
  int n_fail = 0, total_checks = 0, cycles = 0, k;
  rms_sequencer i_rms_sequencer (.*);
  rms_board_model i_rms_board_model (.*);
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end
  // ==========================================================
  // Helpers
  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wait_release();
    k = 0;
    while (system_reset !== 1'b0 && k < 400) begin
      @(negedge clk);
      k++;
    end
    check("release", 8'h01, {7'h00, k < 400});
    @(posedge clk);
    hold_mode_low <= 1'b0;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_por(logic low);
    hold_mode_low <= low;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wait_release();
    check("por_mode", {7'h00, low}, {7'h00, background_debug_state});
    check("por_cause", 8'h01, {4'h0, reset_cause_register});
  endtask
  task automatic t_req(int which, logic low, logic [3:0] cause, logic mode);
    hold_mode_low <= low;
    internal_reset_req <= (which == 0);
    debug_force_reset_bit <= (which == 1);
    press_reset <= (which == 2);
    @(posedge clk);
    internal_reset_req <= 1'b0;
    debug_force_reset_bit <= 1'b0;
    repeat (4) @(posedge clk);
    press_reset <= 1'b0;
    wait_release();
    check("req_cause", {4'h0, cause}, {4'h0, reset_cause_register});
    check("req_mode", {7'h00, mode}, {7'h00, background_debug_state});
  endtask
  task automatic t_link(logic fast, logic bit_val, logic drv);
    logic seen_oe;
    logic seen_hi;
    seen_oe = 1'b0;
    seen_hi = 1'b0;
    fast_clock_select <= fast;
    link_tx_bit <= bit_val;
    link_drive <= drv;
    link_start <= 1'b1;
    @(posedge clk);
    link_start <= 1'b0;
    k = 0;
    while (link_busy !== 1'b1 && k < 10) begin
      @(negedge clk);
      k++;
    end
    k = 0;
    while (link_busy === 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
      seen_oe |= debug_and_mode_pin_oe;
      seen_hi |= debug_and_mode_pin_oe && debug_and_mode_pin_out;
    end
    // First slow tick may land one clock after the start edge
    check("bit_len", 8'h01, {7'h00, k >= (fast ? 16 : 31) && k <= (fast ? 17 : 32)});
    check("bit_done", 8'h01, {7'h00, link_done});
    // Receive-only bits see the pull-up level
    check("bit_rx", {7'h00, drv ? bit_val : 1'b1}, {7'h00, link_rx_bit});
    check("bit_drive", {7'h00, drv}, {7'h00, seen_oe});
    check("bit_speedup", {7'h00, drv}, {7'h00, seen_hi});
    @(posedge clk);
  endtask
  task automatic summarize();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    t_por(1'b1);
    t_por(1'b0);
    t_req(0, 1'b1, 4'h4, 1'b0);
    t_req(1, 1'b1, 4'h8, 1'b1);
    t_req(0, 1'b0, 4'h4, 1'b1);
    t_req(2, 1'b1, 4'h2, 1'b0);
    t_req(1, 1'b0, 4'h8, 1'b0);
    for (int f = 0; f < 2; f++) begin
      t_link(f[0], 1'b1, 1'b1);
      t_link(f[0], 1'b0, 1'b1);
      t_link(f[0], 1'b0, 1'b0);
    end
    summarize();
  end
endmodule // tb_rms_sequencer
